// ===== verilog/urxe_map.svh
/*
  Constants of the serial receiver status block: sample positions,
  frame timing in sample ticks and reset values.
  Assumes the sample tick runs at sixteen ticks per bit.
*/
`ifndef URXE_MAP_SVH
`define URXE_MAP_SVH

// Sample positions within one bit, counted from 1 at the bit's edge.
`define URXE_RT_VER_A 5'h03
`define URXE_RT_VER_B 5'h05
`define URXE_RT_VER_C 5'h07
`define URXE_RT_SMP_A 5'h08
`define URXE_RT_SMP_B 5'h09
`define URXE_RT_SMP_C 5'h0A
`define URXE_RT_LAST 5'h10
`define URXE_RT_FIRST 5'h01

// Sample position and character tick that follow an edge tick, which counts as one.
`define URXE_RT_SECOND 5'h02
`define URXE_TICK_SECOND 8'h02

// Stop sample tick after the start edge: 154 for 8 data bits, 170 for 9.
`define URXE_STOP_TICK_8 8'h9A
`define URXE_STOP_TICK_9 8'hAA

// Idle character: 10 or 11 bit times of ones, in sample ticks.
`define URXE_IDLE_TICKS_8 8'hA0
`define URXE_IDLE_TICKS_9 8'hB0

// Data bit counts per character.
`define URXE_DATA_BITS_8 4'h8
`define URXE_DATA_BITS_9 4'h9

// Reset value of the whole state.
`define URXE_STATE_RST '0

`endif

// ===== verilog/urxe_pkg.sv
/*
  Types of the serial receiver status block.
  Assumes the map header supplies all numeric constants.
*/
`default_nettype none
package urxe_pkg;

  // Receiver sequence; the first state is the reset state.
  typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} urxe_fsm_e;

  // Status flags that hardware sets and software clears.
  typedef struct packed {
    logic full;
    logic idle;
    logic ovr;
    logic noise;
    logic frame;
    logic parity;
  } urxe_flags_s;

  // All state of the block.
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [2:0] hist;
    urxe_fsm_e fsm;
    logic [4:0] rt_cnt;
    logic [3:0] bit_idx;
    logic [2:0] smp;
    logic [8:0] shift;
    logic last_bit;
    logic chr_noise;
    logic resynced;
    logic [7:0] char_ticks;
    logic [7:0] idle_ticks;
    logic idle_armed;
    logic standby;
    urxe_flags_s flg;
    urxe_flags_s armed;
    logic [8:0] data;
    logic rx_irq;
    logic err_irq;
    logic wake;
  } urxe_state_s;

endpackage
`default_nettype wire

// ===== verilog/urxe_top.sv
/*
  Receiver status, error detection, standby wakeup and interrupt requests
  of an asynchronous serial receiver.
  Assumes a one-cycle sample tick at sixteen times the bit rate from a
  baud generator on the same clock, and control pulses from same-clock logic.
  The serial input comes from a pin and is synchronised here.
*/
`include "urxe_map.svh"
`default_nettype none

module urxe_top (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic RXD_IN,
  input wire logic RT_TICK_IN,
  input wire logic RX_ENABLE_IN,
  input wire logic MODE9_IN,
  input wire logic PARITY_EN_IN,
  input wire logic PARITY_ODD_IN,
  input wire logic WAKE_ADDR_IN,
  input wire logic IDLE_COUNT_START_IN,
  input wire logic STANDBY_SET_IN,
  input wire logic RX_FULL_IRQ_ENABLE_IN,
  input wire logic IDLE_IRQ_ENABLE_IN,
  input wire logic OVERRUN_IRQ_ENABLE_IN,
  input wire logic NOISE_IRQ_ENABLE_IN,
  input wire logic FRAMING_IRQ_ENABLE_IN,
  input wire logic PARITY_IRQ_ENABLE_IN,
  input wire logic STATUS_READ_IN,
  input wire logic DATA_READ_IN,
  input wire logic BREAK_STATE_IN,
  input wire logic BREAK_CLEAR_ENABLE_IN,
  input wire logic WAIT_MODE_IN,
  input wire logic STOP_MODE_IN,
  output logic [8:0] RX_DATA_OUT,
  output logic RX_DATA_FULL_FLAG_OUT,
  output logic IDLE_FLAG_OUT,
  output logic OVERRUN_FLAG_OUT,
  output logic NOISE_FLAG_OUT,
  output logic FRAMING_ERROR_FLAG_OUT,
  output logic PARITY_ERROR_FLAG_OUT,
  output logic RX_STANDBY_BIT_OUT,
  output logic RX_IRQ_OUT,
  output logic ERR_IRQ_OUT,
  output logic WAKE_REQ_OUT
);

  urxe_pkg::urxe_state_s st_reg;
  urxe_pkg::urxe_state_s st_next;
  logic rxd;
  logic [2:0] v;
  logic maj;
  logic uni;
  logic fin;
  logic load;
  logic adv;
  logic clr_ok;
  logic [3:0] n_data;
  logic [7:0] idle_lim;
  logic [8:0] word;
  logic par_bad;
  logic fall;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Software clears are applied first so that a hardware set in the same
  // cycle overrides them.
  always_comb begin
    st_next = st_reg;
    rxd = st_reg.sync2;
    v = {rxd, st_reg.smp[2:1]};
    maj = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    uni = (v == 3'h0) || (v == 3'h7);
    fin = 1'b0;
    load = 1'b0;
    adv = 1'b0;
    fall = 1'b0;
    n_data = MODE9_IN ? `URXE_DATA_BITS_9 : `URXE_DATA_BITS_8;
    idle_lim = MODE9_IN ? `URXE_IDLE_TICKS_9 : `URXE_IDLE_TICKS_8;
    word = MODE9_IN ? st_reg.shift : {1'b0, st_reg.shift[8:1]};
    par_bad = PARITY_EN_IN && ((^word) != PARITY_ODD_IN);
    clr_ok = !WAIT_MODE_IN && !(BREAK_STATE_IN && !BREAK_CLEAR_ENABLE_IN);
    // The pin synchroniser keeps running even while the block is halted.
    st_next.sync1 = RXD_IN;
    st_next.sync2 = st_reg.sync1;
    if (!STOP_MODE_IN) begin
      // Two-step clear: a status read arms, a data read clears what was armed.
      if (clr_ok && STATUS_READ_IN) begin
        st_next.armed = st_reg.flg;
      end
      if (clr_ok && DATA_READ_IN) begin
        st_next.flg = urxe_pkg::urxe_flags_s'(st_reg.flg & ~st_reg.armed);
        st_next.armed = '0;
      end
      if (!WAIT_MODE_IN && STANDBY_SET_IN) begin
        st_next.standby = 1'b1;
      end
      if (!RX_ENABLE_IN) begin
        // Disabling aborts a character but leaves every flag alone.
        st_next.fsm = urxe_pkg::R_IDLE;
      end else begin
        if (RT_TICK_IN) begin
          st_next.hist = {st_reg.hist[1:0], rxd};
          st_next.char_ticks = st_reg.char_ticks + 8'h01;
          st_next.rt_cnt = st_reg.rt_cnt + 5'h01;
          if (st_reg.rt_cnt == `URXE_RT_VER_A || st_reg.rt_cnt == `URXE_RT_VER_B ||
              st_reg.rt_cnt == `URXE_RT_VER_C || st_reg.rt_cnt == `URXE_RT_SMP_A ||
              st_reg.rt_cnt == `URXE_RT_SMP_B || st_reg.rt_cnt == `URXE_RT_SMP_C) begin
            st_next.smp = v;
          end
          case (st_reg.fsm)
            urxe_pkg::R_IDLE: begin
              st_next.rt_cnt = `URXE_RT_FIRST;
              // A start edge is a low sample after three high ones.
              if (!rxd && st_reg.hist == 3'h7) begin
                st_next.fsm = urxe_pkg::R_START;
                st_next.rt_cnt = `URXE_RT_SECOND;
                st_next.char_ticks = `URXE_TICK_SECOND;
                st_next.chr_noise = 1'b0;
                st_next.resynced = 1'b0;
                st_next.idle_armed = 1'b1;
              end
            end
            urxe_pkg::R_START: begin
              if (st_reg.rt_cnt == `URXE_RT_VER_C) begin
                if (maj) begin
                  st_next.fsm = urxe_pkg::R_IDLE; // False start, search again.
                end else if (!uni) begin
                  st_next.chr_noise = 1'b1;
                end
              end
              if (st_reg.rt_cnt == `URXE_RT_SMP_C && v != 3'h0) begin
                st_next.chr_noise = 1'b1;
              end
              if (st_reg.rt_cnt == `URXE_RT_LAST) begin
                st_next.fsm = urxe_pkg::R_DATA;
                st_next.rt_cnt = `URXE_RT_FIRST;
                st_next.bit_idx = 4'h1;
                st_next.last_bit = 1'b0;
              end
            end
            urxe_pkg::R_DATA: begin
              if (st_reg.rt_cnt == `URXE_RT_SMP_C) begin
                st_next.shift = {maj, st_reg.shift[8:1]};
                st_next.last_bit = maj;
                if (!uni) begin
                  st_next.chr_noise = 1'b1;
                end
              end
              // A one-to-zero change after a bit decided 1 is a fresh bit edge;
              // the edge tick counts as the first sample of the bit it opens.
              fall = st_reg.last_bit && !rxd && st_reg.hist[0];
              adv = (st_reg.rt_cnt == `URXE_RT_LAST) ||
                    (st_reg.rt_cnt > `URXE_RT_SMP_C && fall);
              if (adv) begin
                st_next.rt_cnt = fall ? `URXE_RT_SECOND : `URXE_RT_FIRST;
                if (fall) begin
                  st_next.resynced = 1'b1;
                end
                if (st_reg.bit_idx == n_data) begin
                  st_next.fsm = urxe_pkg::R_STOP;
                end else begin
                  st_next.bit_idx = st_reg.bit_idx + 4'h1;
                end
              end else if (fall && st_reg.rt_cnt < `URXE_RT_SMP_A) begin
                // A slow sender's edge lands early in the bit, so the bit restarts.
                st_next.rt_cnt = `URXE_RT_SECOND;
                if (st_reg.rt_cnt != `URXE_RT_FIRST) begin
                  st_next.resynced = 1'b1;
                end
              end
            end
            urxe_pkg::R_STOP: begin
              if (st_reg.rt_cnt == `URXE_RT_SMP_C) begin
                fin = 1'b1;
                st_next.fsm = urxe_pkg::R_IDLE;
              end
            end
            default: begin
              st_next.fsm = urxe_pkg::R_IDLE;
            end
          endcase
          // Idle counting: with the stop bit setting only ones outside a
          // character count, which avoids false idle on data full of ones.
          if (!rxd || (IDLE_COUNT_START_IN && st_reg.fsm != urxe_pkg::R_IDLE)) begin
            st_next.idle_ticks = 8'h00;
          end else if (st_reg.idle_ticks < idle_lim) begin
            st_next.idle_ticks = st_reg.idle_ticks + 8'h01;
          end
        end
        // A character ends at the middle of its stop bit.
        if (fin) begin
          if (st_next.standby) begin
            if (WAKE_ADDR_IN && st_reg.shift[8]) begin
              st_next.standby = 1'b0;
              load = 1'b1;
            end
          end else if (st_next.flg.full) begin
            st_next.flg.ovr = 1'b1;
          end else begin
            load = 1'b1;
          end
        end
        if (load) begin
          st_next.data = word;
          st_next.flg.full = 1'b1;
          if (!maj) begin
            st_next.flg.frame = 1'b1;
          end
          if (st_reg.chr_noise || !uni) begin
            st_next.flg.noise = 1'b1;
          end
          if (par_bad) begin
            st_next.flg.parity = 1'b1;
          end
        end
        // The idle line has been seen; a waiting standby wakes even when the
        // line was already idle, which software has to expect.
        if (st_reg.idle_ticks >= idle_lim) begin
          if (st_next.standby && !WAKE_ADDR_IN) begin
            st_next.standby = 1'b0;
            st_next.idle_armed = 1'b0;
          end else if (!st_next.standby && st_reg.idle_armed) begin
            st_next.flg.idle = 1'b1;
            st_next.idle_armed = 1'b0;
          end
        end
      end
    end
    // Requests follow the flags at the same edge.
    st_next.rx_irq = !st_next.standby &&
                     ((st_next.flg.full && RX_FULL_IRQ_ENABLE_IN) ||
                      (st_next.flg.idle && IDLE_IRQ_ENABLE_IN));
    st_next.err_irq = (st_next.flg.ovr && OVERRUN_IRQ_ENABLE_IN) ||
                      (st_next.flg.noise && NOISE_IRQ_ENABLE_IN) ||
                      (st_next.flg.frame && FRAMING_IRQ_ENABLE_IN) ||
                      (st_next.flg.parity && PARITY_IRQ_ENABLE_IN);
    st_next.wake = WAIT_MODE_IN && (st_next.rx_irq || st_next.err_irq);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // Reset clears all state, the standby bit among it.
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st_reg <= `URXE_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output is a field of the state register.
  assign RX_DATA_OUT = st_reg.data;
  assign RX_DATA_FULL_FLAG_OUT = st_reg.flg.full;
  assign IDLE_FLAG_OUT = st_reg.flg.idle;
  assign OVERRUN_FLAG_OUT = st_reg.flg.ovr;
  assign NOISE_FLAG_OUT = st_reg.flg.noise;
  assign FRAMING_ERROR_FLAG_OUT = st_reg.flg.frame;
  assign PARITY_ERROR_FLAG_OUT = st_reg.flg.parity;
  assign RX_STANDBY_BIT_OUT = st_reg.standby;
  assign RX_IRQ_OUT = st_reg.rx_irq;
  assign ERR_IRQ_OUT = st_reg.err_irq;
  assign WAKE_REQ_OUT = st_reg.wake;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Framing error never rises without the full flag rising with it.
  AST_FE_WITH_FULL:
    assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
      $rose(FRAMING_ERROR_FLAG_OUT) |-> $rose(RX_DATA_FULL_FLAG_OUT))
    else $error("framing error rose without data full");

  // Without realignment the stop decision falls on the documented tick.
  AST_STOP_TICK:
    assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
      (fin && !st_reg.resynced) |->
      st_reg.char_ticks == (MODE9_IN ? `URXE_STOP_TICK_9 : `URXE_STOP_TICK_8))
    else $error("stop sample at wrong tick");

  // A loaded character with a low stop majority reports a framing error.
  AST_FE_ON_LOW_STOP:
    assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
      (load && !maj) |=> FRAMING_ERROR_FLAG_OUT && RX_DATA_FULL_FLAG_OUT)
    else $error("missing stop bit not flagged");

  // Standby keeps the receive request low.
  AST_STANDBY_QUIET:
    assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
      RX_STANDBY_BIT_OUT |-> !RX_IRQ_OUT)
    else $error("receive request during standby");

  // An address mark in standby wakes the receiver and fills the buffer.
  AST_ADDR_WAKE:
    assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
      (fin && st_reg.standby && WAKE_ADDR_IN && st_reg.shift[8] && !STOP_MODE_IN)
      |=> !RX_STANDBY_BIT_OUT && RX_DATA_FULL_FLAG_OUT)
    else $error("address mark did not wake");

  // Idle-line wakeup sets neither idle nor full.
  AST_IDLE_WAKE_QUIET:
    assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
      ($fell(RX_STANDBY_BIT_OUT) && !$past(WAKE_ADDR_IN)) |->
      !$rose(IDLE_FLAG_OUT) && !$rose(RX_DATA_FULL_FLAG_OUT))
    else $error("idle wakeup set a flag");

  // Overrun leaves the buffered character untouched.
  AST_OVR_KEEP:
    assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
      $rose(OVERRUN_FLAG_OUT) |-> $stable(RX_DATA_OUT))
    else $error("overrun replaced buffered data");

  // The error request is the OR of enabled error flags.
  AST_ERR_OR:
    assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
      ##1 ERR_IRQ_OUT == ((OVERRUN_FLAG_OUT && $past(OVERRUN_IRQ_ENABLE_IN)) ||
                          (NOISE_FLAG_OUT && $past(NOISE_IRQ_ENABLE_IN)) ||
                          (FRAMING_ERROR_FLAG_OUT && $past(FRAMING_IRQ_ENABLE_IN)) ||
                          (PARITY_ERROR_FLAG_OUT && $past(PARITY_IRQ_ENABLE_IN))))
    else $error("error request mismatch");

  // A protected debug break lets no status flag fall.
  AST_BREAK_HOLD:
    assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
      (BREAK_STATE_IN && !BREAK_CLEAR_ENABLE_IN) |=>
      (st_reg.flg & ~$past(st_reg.flg)) == (st_reg.flg ^ $past(st_reg.flg)))
    else $error("status changed by clear during break");

  // Stop mode freezes the receiver sequence and status.
  AST_STOP_FREEZE:
    assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
      STOP_MODE_IN |=> $stable(st_reg.fsm) && $stable(st_reg.flg) && $stable(RX_DATA_OUT))
    else $error("state moved in stop mode");

endmodule
`default_nettype wire

// ===== tb/urxe_far_tx.sv
/*
  Far-end transmitter model: plays one line level per sample tick.
  Assumes a one-cycle sample tick on the same clock as the receiver.
*/
`default_nettype none
module urxe_far_tx (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  output logic rxd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  bit lv_q[$];
  ////////////////////////////////////////////////////////////////////////////////
  // The level changes just after a tick, so entry k is seen at sample k+1.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rxd_out <= 1'b1;
    end else if (tick_in) begin
      rxd_out <= (lv_q.size() > 0) ? lv_q.pop_front() : 1'b1; // Pull-up holds idle high.
    end
  end
  // Start bit, data LSB first, then sixteen stop-sample levels (all low for a break).
  task automatic frame(input logic [8:0] d, input int nb, input int blen,
                       input logic [15:0] stop_lv);
    for (int i = 0; i < blen; i++) lv_q.push_back(1'b0);
    for (int b = 0; b < nb; b++)
      for (int i = 0; i < blen; i++) lv_q.push_back(d[b]);
    for (int i = 0; i < 16; i++) lv_q.push_back(stop_lv[i]);
  endtask
endmodule
`default_nettype wire

// ===== tb/urxe_top_bench.sv
/*
  Self-checking bench of the receiver status block with a behavioural model.
  Assumes the design and the far-end transmitter model are compiled first.
*/
`default_nettype none
module urxe_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, tick, rxd, mode9, par_en, par_odd, wake_addr, idle_count_start_bit, sb_set, rx_en;
  logic st_rd, dt_rd, brk, bce, wait_m, stop_m, en_full, en_idle, en_ovr, en_noise;
  logic en_frame, en_par, pf, pfr, e_full, e_idle, e_ovr, e_noise, e_frame, e_par, e_sb;
  logic q_full, q_idle, q_ovr, q_noise, q_frame, q_par, q_sb, q_rxi, q_erri, q_wake;
  logic [8:0] q_data, e_data, d;
  logic [1:0] tdiv;
  logic [15:0] stp_t [4] = '{16'hFEFF, 16'hFE7F, 16'h0000, 16'h0000};
  bit fr_t [4] = '{0, 1, 1, 1};
  bit nz_t [4] = '{1, 1, 0, 0};
  int n_fail, checked, cyc, seed, t_st, t_full, t_fr;
  urxe_top dut (
    .CLK_IN(clk), .RSTN_IN(rst_n), .RXD_IN(rxd), .RT_TICK_IN(tick), .RX_ENABLE_IN(rx_en),
    .MODE9_IN(mode9), .PARITY_EN_IN(par_en), .PARITY_ODD_IN(par_odd),
    .WAKE_ADDR_IN(wake_addr), .IDLE_COUNT_START_IN(idle_count_start_bit), .STANDBY_SET_IN(sb_set),
    .RX_FULL_IRQ_ENABLE_IN(en_full), .IDLE_IRQ_ENABLE_IN(en_idle),
    .OVERRUN_IRQ_ENABLE_IN(en_ovr), .NOISE_IRQ_ENABLE_IN(en_noise),
    .FRAMING_IRQ_ENABLE_IN(en_frame), .PARITY_IRQ_ENABLE_IN(en_par),
    .STATUS_READ_IN(st_rd), .DATA_READ_IN(dt_rd), .BREAK_STATE_IN(brk),
    .BREAK_CLEAR_ENABLE_IN(bce), .WAIT_MODE_IN(wait_m), .STOP_MODE_IN(stop_m),
    .RX_DATA_OUT(q_data), .RX_DATA_FULL_FLAG_OUT(q_full), .IDLE_FLAG_OUT(q_idle),
    .OVERRUN_FLAG_OUT(q_ovr), .NOISE_FLAG_OUT(q_noise), .FRAMING_ERROR_FLAG_OUT(q_frame),
    .PARITY_ERROR_FLAG_OUT(q_par), .RX_STANDBY_BIT_OUT(q_sb), .RX_IRQ_OUT(q_rxi),
    .ERR_IRQ_OUT(q_erri), .WAKE_REQ_OUT(q_wake));
  urxe_far_tx tx (.clk_in(clk), .rst_n_in(rst_n), .tick_in(tick), .rxd_out(rxd));
  ////////////////////////////////////////////////////////////////////////////////
  always #4 clk = ~clk;
  // Sample tick every fourth clock, so one bit time is 64 clocks.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdiv <= 2'h0;
      tick <= 1'b0;
    end else begin
      tdiv <= tdiv + 2'h1;
      tick <= (tdiv == 2'h3);
    end
  end
  // Cycle count; a hang is cut short well above the expected run length.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end
  // Stamps of the latest rise of data full and of framing error.
  always @(negedge clk) begin
    if (q_full && !pf) t_full = cyc;
    if (q_frame && !pfr) t_fr = cyc;
    pf = q_full;
    pfr = q_frame;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chkd(input string nm, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  // One clock of clear steps or a standby set, then all low again.
  task automatic step(input logic s, input logic r, input logic b);
    @(posedge clk);
    st_rd <= s;
    dt_rd <= r;
    sb_set <= b;
    @(posedge clk);
    st_rd <= 1'b0;
    dt_rd <= 1'b0;
    sb_set <= 1'b0;
  endtask
  task automatic clr();
    step(1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    {e_full, e_idle, e_ovr, e_noise, e_frame, e_par} = '0;
  endtask
  task automatic rand_en();
    @(posedge clk);
    {en_full, en_idle, en_ovr, en_noise, en_frame, en_par} <= 6'($random(seed));
  endtask
  // Plays a character and waits, bounded, until the line has gone idle.
  task automatic send(input logic [8:0] v, input int blen, input logic [15:0] stp);
    t_st = cyc;
    tx.frame(v, mode9 ? 9 : 8, blen, stp);
    for (int i = 0; i < 4000 && tx.lv_q.size() > 0; i++) @(posedge clk);
    repeat (12) @(posedge clk);
  endtask
  // Model of a loaded character: a full buffer keeps its data and flags overrun.
  task automatic got(input logic [8:0] v, input logic fr, input logic nz, input logic pe);
    if (e_full) e_ovr = 1'b1;
    else begin
      e_data = v;
      e_full = 1'b1;
      e_frame |= fr;
      e_noise |= nz;
      e_par |= pe;
    end
  endtask
  // Requests are checked two edges late, since they follow flags and enables.
  task automatic check_all();
    logic rxi, eri;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rxi = !e_sb && (e_full && en_full || e_idle && en_idle);
    eri = e_ovr && en_ovr || e_noise && en_noise || e_frame && en_frame || e_par && en_par;
    chkd("data", e_data, q_data);
    chkb("full", e_full, q_full);
    chkb("idle", e_idle, q_idle);
    chkb("overrun", e_ovr, q_ovr);
    chkb("noise", e_noise, q_noise);
    chkb("framing", e_frame, q_frame);
    chkb("parity", e_par, q_par);
    chkb("standby", e_sb, q_sb);
    chkb("rx_irq", rxi, q_rxi);
    chkb("err_irq", eri, q_erri);
    chkb("wake", wait_m && (rxi || eri), q_wake);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, rst_n, mode9, par_en, par_odd, wake_addr, idle_count_start_bit, sb_set, st_rd, dt_rd} = '0;
    {brk, bce, wait_m, stop_m, en_full, en_idle, en_ovr, en_noise, en_frame, en_par} = '0;
    {e_full, e_idle, e_ovr, e_noise, e_frame, e_par, e_sb, e_data} = '0;
    seed = 54;
    rx_en = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    idle_count_start_bit <= 1'b1;
    repeat (40) @(posedge clk);
    check_all();
    // Clean characters, then a timing stamp of the stop sample.
    for (int k = 0; k < 4; k++) begin
      rand_en();
      d = 9'($random(seed)) & 9'h0FF;
      send(d, 16, 16'hFFFF);
      got(d, 1'b0, 1'b0, 1'b0);
      check_all();
      chkb("stop_tick", 1'b1, (t_full - t_st) inside {[612:630]});
      clr();
    end
    // A second character before any clear is dropped.
    send(9'h0A5, 16, 16'hFFFF);
    got(9'h0A5, 1'b0, 1'b0, 1'b0);
    send(9'h03C, 16, 16'hFFFF);
    got(9'h03C, 1'b0, 1'b0, 1'b0);
    check_all();
    clr();
    // Stop samples: one low, two low, all low, then a break character.
    for (int k = 0; k < 4; k++) begin
      rand_en();
      d = (k == 3) ? 9'h000 : 9'($random(seed)) & 9'h0FF;
      send(d, 16, stp_t[k]);
      got(d, fr_t[k], nz_t[k], 1'b0);
      check_all();
      chkb("frame_with_full", fr_t[k], t_fr == t_full);
      clr();
    end
    // Sender faster, then slower, by one tick per bit; falling edges realign.
    for (int k = 0; k < 2; k++) begin
      send(9'h055, 15 + 2 * k, 16'hFFFF);
      got(9'h055, 1'b0, 1'b0, 1'b0);
      check_all();
      clr();
    end
    // Nine data bits move the stop sample one bit time later.
    @(posedge clk);
    mode9 <= 1'b1;
    d = 9'($random(seed));
    // Let the new length settle, since the frame is built from it.
    @(posedge clk);
    send(d, 16, 16'hFFFF);
    got(d, 1'b0, 1'b0, 1'b0);
    check_all();
    chkb("stop_tick9", 1'b1, (t_full - t_st) inside {[676:694]});
    clr();
    @(posedge clk);
    mode9 <= 1'b0;
    par_en <= 1'b1;
    // Even and odd parity, each with a right and a wrong parity bit.
    for (int k = 0; k < 4; k++) begin
      rand_en();
      par_odd <= k[0];
      d = 9'($random(seed)) & 9'h07F;
      d[7] = ^d[6:0] ^ k[0] ^ k[1];
      send(d, 16, 16'hFFFF);
      got(d, 1'b0, 1'b0, k[1]);
      check_all();
      clr();
    end
    // Idle flag, counting from the stop bit and then from the start bit.
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      par_en <= 1'b0;
      idle_count_start_bit <= ~k[0];
      send(9'h0B2, 16, 16'hFFFF);
      got(9'h0B2, 1'b0, 1'b0, 1'b0);
      check_all();
      repeat (896) @(posedge clk);
      e_idle = 1'b1;
      check_all();
      clr();
    end
    // Address-mark wakeup: a plain character is dropped, a marked one wakes.
    @(posedge clk);
    wake_addr <= 1'b1;
    step(1'b0, 1'b0, 1'b1);
    e_sb = 1'b1;
    send(9'h012, 16, 16'hFFFF);
    check_all();
    send(9'h0C4, 16, 16'hFFFF);
    e_sb = 1'b0;
    got(9'h0C4, 1'b0, 1'b0, 1'b0);
    check_all();
    // Address mismatch: back to standby, now waiting for an idle line.
    @(posedge clk);
    wake_addr <= 1'b0;
    step(1'b0, 1'b0, 1'b1);
    e_sb = 1'b1;
    check_all();
    repeat (896) @(posedge clk);
    e_sb = 1'b0;
    check_all();
    // A clear begun before a protected break finishes only after it.
    step(1'b1, 1'b0, 1'b0);
    @(posedge clk);
    brk <= 1'b1;
    step(1'b0, 1'b1, 1'b0);
    check_all();
    @(posedge clk);
    brk <= 1'b0;
    step(1'b0, 1'b1, 1'b0);
    e_full = 1'b0;
    check_all();
    // With clear enable, a clear inside the break sticks.
    send(9'h0C3, 16, 16'hFFFF);
    got(9'h0C3, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    brk <= 1'b1;
    bce <= 1'b1;
    clr();
    @(posedge clk);
    brk <= 1'b0;
    bce <= 1'b0;
    check_all();
    // Wait mode: reception goes on, reads are ignored, an enabled request wakes.
    @(posedge clk);
    wait_m <= 1'b1;
    en_full <= 1'b1;
    send(9'h05A, 16, 16'hFFFF);
    got(9'h05A, 1'b0, 1'b0, 1'b0);
    step(1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    check_all();
    // Stop mode freezes the receiver, so a character then overruns nothing.
    @(posedge clk);
    wait_m <= 1'b0;
    stop_m <= 1'b1;
    send(9'h0F0, 16, 16'hFFFF);
    check_all();
    @(posedge clk);
    stop_m <= 1'b0;
    check_all();
    // Dropping the enable mid-character aborts it and keeps every flag.
    tx.frame(9'h033, 8, 16, 16'hFFFF);
    repeat (300) @(posedge clk);
    rx_en <= 1'b0;
    repeat (400) @(posedge clk);
    rx_en <= 1'b1;
    check_all();
    summarize();
  end
endmodule
`default_nettype wire
